// [bench/mkx_ks_gen.sv]
// Key stream generator model feeding the mapper
module mkx_ks_gen
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Flow control
  input  wire logic ks_ready_i,
  input  wire logic slow_i,
  // Key stream
  output logic      ks_valid_o,
  output logic      ks_bit_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] lfsr = 16'hACE1;
  logic        take;

  initial
  begin
    ks_valid_o = 1'b0;
    ks_bit_o   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit held until taken; idle line toggles so stale values never match
  always @(posedge clock_i)
  begin
    take = ks_valid_o && ks_ready_i;
    #1;
    if (!rst_n_i)
    begin
      ks_valid_o = 1'b0;
      ks_bit_o   = ~ks_bit_o;
    end
    else if (take || !ks_valid_o)
    begin
      lfsr       = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      ks_valid_o = !(slow_i && lfsr[3]);
      ks_bit_o   = ks_valid_o ? lfsr[0] : ~ks_bit_o;
    end
  end
endmodule

// [bench/mkx_mapper_tb.sv]
// Self-checking bench of the key stream XOR mapper
module mkx_mapper_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mkx_pkg::*;

  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        frame_start_i = 1'b0;
  logic        field_start_i = 1'b0;
  mkx_cfg_t    cfg_i = MKX_CFG_1A;
  mkx_slot_t   slot_i = MKX_SLOT_DOUBLE;
  logic        ctrl_tail_i = 1'b0;
  mkx_bfmt_t   bfmt_i = MKX_BF_UNPROT;
  logic        slow_i = 1'b0;
  logic        data_bit_i = 1'b0;
  logic        ks_valid_i;
  logic        ks_bit_i;
  logic        ks_ready_o;
  logic        out_valid_o;
  logic        out_bit_o;
  mkx_len_t    out_pos_o;
  logic        out_tail_o;
  logic        seg_done_o;
  logic        seg_second_o;
  mkx_len_t    seg_len_o;
  logic [3:0]  a_levels_o;
  int          err_total = 0;
  int          cmp_count = 0;
  logic [31:0] rnd = 32'hD46B112D;
  logic [15:0] exp_q[$];
  int          k, tl, bl, rc, n;
  logic        done_pend = 1'b0;
  logic        seg_finished = 1'b0;
  logic        exp_second = 1'b0;
  logic        xr;

  always #5 clock_i = ~clock_i;

  mkx_mapper DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .frame_start_i(frame_start_i),
    .field_start_i(field_start_i), .cfg_i(cfg_i), .slot_i(slot_i), .ctrl_tail_i(ctrl_tail_i),
    .bfmt_i(bfmt_i), .ks_valid_i(ks_valid_i), .ks_bit_i(ks_bit_i), .data_bit_i(data_bit_i),
    .ks_ready_o(ks_ready_o), .out_valid_o(out_valid_o), .out_bit_o(out_bit_o),
    .out_pos_o(out_pos_o), .out_tail_o(out_tail_o), .seg_done_o(seg_done_o),
    .seg_second_o(seg_second_o), .seg_len_o(seg_len_o), .a_levels_o(a_levels_o));

  mkx_ks_gen u_gen (.clock_i(clock_i), .rst_n_i(rst_n_i), .ks_ready_i(ks_ready_o),
    .slow_i(slow_i), .ks_valid_o(ks_valid_i), .ks_bit_o(ks_bit_i));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Random field data every cycle
  always @(posedge clock_i)
  begin
    #1;
    rnd        = lfsr_next(rnd);
    data_bit_i = rnd[7];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference model: notes each expected field bit as a key bit is taken
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      // Reset returns the selection to the first segment
      done_pend  = 1'b0;
      exp_second = 1'b0;
    end
    else
    begin
      if (done_pend)
      begin
        check({15'h0, seg_done_o}, 16'h0001);
        done_pend    = 1'b0;
        exp_second   = ~exp_second;
        seg_finished = 1'b1;
      end
      if (frame_start_i)
        exp_second = 1'b0;
      if (field_start_i)
      begin
        check({15'h0, seg_second_o}, {15'h0, exp_second});
        tl = (cfg_i == MKX_CFG_4A) ? 80 : (cfg_i == MKX_CFG_4B) ? 120 : 40;
        // B portion by slot and configuration
        bl = (slot_i == MKX_SLOT_DOUBLE) ? 800 : (slot_i == MKX_SLOT_FULL) ? 320 :
             (slot_i == MKX_SLOT_HALF) ? 80 : (slot_i == MKX_SLOT_LONG640) ? 640 : 672;
        case (cfg_i)
          MKX_CFG_2, MKX_CFG_4A: bl = bl * 2;
          MKX_CFG_3, MKX_CFG_4B: bl = bl * 3;
          MKX_CFG_5:             bl = bl * 4;
          MKX_CFG_6:             bl = bl * 6;
          default:               bl = bl;
        endcase
        rc = (bl <= 320) ? 16 : 32;
        k  = 0;
      end
      else if (ks_valid_i && ks_ready_o)
      begin
        // tail bits onto A bit 8+k or discarded
        if (k < tl && ctrl_tail_i)
          exp_q.push_back({data_bit_i ^ ks_bit_i, 1'b1, 14'(k + 8)});
        else if (k >= tl)
        begin
          // body bits, check portions left clear
          xr = (bfmt_i == MKX_BF_UNPROT) || (bfmt_i == MKX_BF_SINGLE && k - tl < bl - rc) ||
               (bfmt_i == MKX_BF_MULTI && (k - tl) % 80 < 64);
          exp_q.push_back({data_bit_i ^ (ks_bit_i & xr), 1'b0, 14'(k - tl)});
        end
        k++;
        // segment ends at index length minus one
        if (k == tl + bl)
        begin
          done_pend = 1'b1;
          check({3'h0, seg_len_o}, 16'(tl + bl));
          check({12'h0, a_levels_o}, (cfg_i == MKX_CFG_4A) ? 16'h0004 :
                                     (cfg_i == MKX_CFG_4B) ? 16'h0008 : 16'h0002);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output watcher: oldest note against each emitted bit
  always @(posedge clock_i)
  begin
    if (rst_n_i && out_valid_o === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(16'hFFFF, 16'h0000);
      else
        check({out_bit_o, out_tail_o, 1'b0, out_pos_o}, exp_q.pop_front());
    end
  end

  // setup presented with the field start pulse
  task automatic run_field(input int c, input int s, input logic ct, input int b, input logic sl);
    @(posedge clock_i);
    #1;
    cfg_i         = mkx_cfg_t'(c);
    slot_i        = mkx_slot_t'(s);
    ctrl_tail_i   = ct;
    bfmt_i        = mkx_bfmt_t'(b);
    slow_i        = sl;
    seg_finished  = 1'b0;
    field_start_i = 1'b1;
    @(posedge clock_i);
    #1;
    field_start_i = 1'b0;
    n = 0;
    while (!seg_finished && n < 20000)
    begin
      @(posedge clock_i);
      n++;
    end
    if (!seg_finished)
      check(16'h0000, 16'h0001);
    $display("Field cfg %0d slot %0d ctrl %0d fmt %0d done, errors %0d", c, s, ct, b, err_total);
  endtask

  initial
  begin
    #800000;
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    repeat (10) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    frame_start_i = 1'b1;
    @(posedge clock_i);
    #1;
    frame_start_i = 1'b0;
    for (int c = 0; c < 8; c++)
      run_field(c, c % 5, c[0], c % 3, c[1]);
    for (int s = 0; s < 5; s++)
      run_field(4 + s % 2, s, 1'b1, (s + 1) % 3, s[0]);
    // Frame start with the second segment pending selects the first again
    @(posedge clock_i);
    #1;
    frame_start_i = 1'b1;
    @(posedge clock_i);
    #1;
    frame_start_i = 1'b0;
    run_field(7, 0, 1'b0, 1, 1'b0);
    run_field(7, 4, 1'b1, 1, 1'b1);
    // Mid-run reset returns the outputs to idle
    #1;
    rst_n_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    check({15'h0, ks_ready_o}, 16'h0000);
    check({12'h0, a_levels_o}, 16'h0002);
    rst_n_i = 1'b1;
    run_field(5, 2, 1'b1, 0, 1'b0);
    repeat (4) @(posedge clock_i);
    check(16'(exp_q.size()), 16'h0000);
    tally_and_finish();
  end
endmodule

// [hdl/mkx_bit_map.sv]
// Per-bit decision: which field bit a segment bit meets and whether it is XORed
module mkx_bit_map
(
  // Position and field setup
  input  wire mkx_pkg::mkx_len_t  idx_i,
  input  wire mkx_pkg::mkx_len_t  tail_len_i,
  input  wire mkx_pkg::mkx_len_t  b_len_i,
  input  wire mkx_pkg::mkx_len_t  rc_len_i,
  input  wire logic               ctrl_tail_i,
  input  wire mkx_pkg::mkx_bfmt_t bfmt_i,
  // Decision
  output logic                    in_tail_o,
  output logic                    emit_o,
  output logic                    xor_o,
  output mkx_pkg::mkx_len_t       pos_o
);
  import mkx_pkg::*;

  mkx_len_t b_idx;

  assign in_tail_o = (idx_i < tail_len_i);
  assign b_idx     = MKX_LEN_W'(idx_i - tail_len_i);

  always_comb
  begin
    emit_o = 1'b1;
    xor_o  = 1'b1;
    pos_o  = b_idx;
    if (in_tail_o)
    begin
      // R9 R10 R13 R16: tail bits only for control tails
      emit_o = ctrl_tail_i;
      xor_o  = ctrl_tail_i;
      pos_o  = MKX_LEN_W'(MKX_A_FIRST_BIT + idx_i);
    end
    else
    begin
      case (bfmt_i)
        // R11 R14 R17: unprotected offset by tail
        MKX_BF_UNPROT: xor_o = 1'b1;
        // R19 R2: check bits stay clear
        MKX_BF_SINGLE: xor_o = (b_idx < MKX_LEN_W'(b_len_i - rc_len_i));
        // R2: only 64 data bits per subfield
        MKX_BF_MULTI:  xor_o = ((b_idx % MKX_SUB_LEN) < MKX_SUB_DATA);
        default:       xor_o = 1'b0;
      endcase
    end
  end

endmodule

// [hdl/mkx_mapper.sv]
// Top of the key stream XOR mapper for multilevel modulation
//
// Summary of operation
// R1: Eight configurations; A-field 4-level in 4a, 8-level in 4b, else 2-level.
// R2: Protected B-fields keep redundancy check and X-field bits unencrypted.
// R3: Each D-field pair consumes two segments, length by slot and configuration.
// R4: Segment is tail plus B portion; tail 40, 80 for 4a, 120 for 4b.
// R5: Double slot B portion 800, 1600, 2400, 3200 or 4800 by configuration.
// R6: Full slot B portion 320 to 1920; half slot 80 to 480.
// R7: Long slots j 640 or 672 scale B portion by bits per symbol.
// R8: Segment bits indexed from zero to length minus one in arrival order.
// R9: Control tail, 2-level A-field: segment bits 0..39 XOR A bits 8..47.
// R10: Non-control tail, 2-level A-field: segment bits 0..39 discarded.
// R11: Unprotected B, 2-level A-field: B bit i XOR segment bit i+40.
// R12: Config 4a control tail: segment bits 0..79 XOR A bits 8..87.
// R13: Config 4a non-control tail: segment bits 0..79 discarded.
// R14: Config 4a unprotected B: bit i XOR segment bit i+80.
// R15: Config 4b control tail: segment bits 0..119 XOR A bits 8..127.
// R16: Config 4b non-control tail: segment bits 0..119 discarded.
// R17: Config 4b unprotected B: bit i XOR segment bit i+120.
// R18: Covered B data bit count follows slot type and configuration.
// R19: Single subfield protected B: bit i XOR segment bit i+tail.
// R20: Double simplex: first segment on first D-field, second on second.
// R21: Receive path uses the same mapping, so XOR again restores plaintext.
// R22: Framing presents field setup before the field's first segment bit.
module mkx_mapper
(
  // Clock and reset
  input  wire logic               clock_i,
  input  wire logic               rst_n_i,
  // Framing
  input  wire logic               frame_start_i,
  input  wire logic               field_start_i,
  input  wire mkx_pkg::mkx_cfg_t  cfg_i,
  input  wire mkx_pkg::mkx_slot_t slot_i,
  input  wire logic               ctrl_tail_i,
  input  wire mkx_pkg::mkx_bfmt_t bfmt_i,
  // Key stream and field data
  input  wire logic               ks_valid_i,
  input  wire logic               ks_bit_i,
  input  wire logic               data_bit_i,
  // Mapped output
  output logic                    ks_ready_o,
  output logic                    out_valid_o,
  output logic                    out_bit_o,
  output mkx_pkg::mkx_len_t       out_pos_o,
  output logic                    out_tail_o,
  // Segment status
  output logic                    seg_done_o,
  output logic                    seg_second_o,
  output mkx_pkg::mkx_len_t       seg_len_o,
  output logic [3:0]              a_levels_o
);
  import mkx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  mkx_state_t state;
  mkx_state_t next_state;
  mkx_cfg_t   cfg_q;
  mkx_slot_t  slot_q;
  mkx_bfmt_t  bfmt_q;
  logic       ctrl_q;
  mkx_len_t   idx;
  mkx_len_t   tail_len;
  mkx_len_t   b_len;
  mkx_len_t   rc_len;
  mkx_len_t   seg_len;
  logic       in_tail;
  logic       emit;
  logic       do_xor;
  mkx_len_t   pos;
  logic       consume;
  logic       last;
  logic       tail_end;

  ////////////////////////////////////////////////////////////////////////////
  mkx_seg_len u_len
  (
    .cfg_i      (cfg_q),
    .slot_i     (slot_q),
    .tail_len_o (tail_len),
    .b_len_o    (b_len),
    .rc_len_o   (rc_len),
    .seg_len_o  (seg_len)
  );

  mkx_bit_map u_map
  (
    .idx_i       (idx),
    .tail_len_i  (tail_len),
    .b_len_i     (b_len),
    .rc_len_i    (rc_len),
    .ctrl_tail_i (ctrl_q),
    .bfmt_i      (bfmt_q),
    .in_tail_o   (in_tail),
    .emit_o      (emit),
    .xor_o       (do_xor),
    .pos_o       (pos)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Ready is a flop, so a bit is only taken while a field is open
  assign consume  = ks_valid_i && ks_ready_o;
  // R8: index runs to length minus one
  assign last     = (idx == MKX_LEN_W'(seg_len - 13'h0001));
  assign tail_end = (idx == MKX_LEN_W'(tail_len - 13'h0001));

  always_comb
  begin
    next_state = state;
    case (state)
      MKX_ST_IDLE: next_state = MKX_ST_IDLE;
      MKX_ST_TAIL:
      begin
        if (consume && tail_end)
        begin
          next_state = MKX_ST_BODY;
        end
      end
      MKX_ST_BODY:
      begin
        if (consume && last)
        begin
          next_state = MKX_ST_IDLE;
        end
      end
      default: next_state = MKX_ST_IDLE;
    endcase
    // A new field restarts the segment even mid-stream
    if (field_start_i)
    begin
      next_state = MKX_ST_TAIL;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state      <= MKX_ST_IDLE;
      ks_ready_o <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      ks_ready_o <= (next_state != MKX_ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // R22: setup captured at field start
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_q      <= MKX_CFG_1A;
      slot_q     <= MKX_SLOT_FULL;
      bfmt_q     <= MKX_BF_UNPROT;
      ctrl_q     <= 1'b0;
      a_levels_o <= MKX_LEVELS_2;
    end
    else if (field_start_i)
    begin
      cfg_q  <= cfg_i;
      slot_q <= slot_i;
      bfmt_q <= bfmt_i;
      ctrl_q <= ctrl_tail_i;
      // R1: A-field levels by config
      case (cfg_i)
        MKX_CFG_4A: a_levels_o <= MKX_LEVELS_4;
        MKX_CFG_4B: a_levels_o <= MKX_LEVELS_8;
        default:    a_levels_o <= MKX_LEVELS_2;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      seg_len_o <= '0;
    end
    else
    begin
      seg_len_o <= seg_len;
    end
  end

  // R8: one index step per taken bit
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      idx <= '0;
    end
    else if (field_start_i)
    begin
      idx <= '0;
    end
    else if (consume)
    begin
      idx <= last ? '0 : MKX_LEN_W'(idx + 13'h0001);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // R21: same XOR serves encrypt and decrypt
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_valid_o <= 1'b0;
      out_bit_o   <= 1'b0;
      out_pos_o   <= '0;
      out_tail_o  <= 1'b0;
    end
    else
    begin
      // R10: discarded bits raise no valid
      out_valid_o <= consume && emit;
      if (consume)
      begin
        out_bit_o  <= data_bit_i ^ (ks_bit_i & do_xor);
        out_pos_o  <= pos;
        out_tail_o <= in_tail;
      end
    end
  end

  // R3 R20: alternate first and second segment
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      seg_done_o   <= 1'b0;
      seg_second_o <= 1'b0;
    end
    else
    begin
      seg_done_o <= consume && last && !field_start_i;
      if (frame_start_i)
      begin
        seg_second_o <= 1'b0;
      end
      else if (seg_done_o)
      begin
        seg_second_o <= !seg_second_o;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_LEVELS: assert property ( // R1
    ks_ready_o |-> (a_levels_o == ((cfg_q == MKX_CFG_4A) ? MKX_LEVELS_4 :
                                   (cfg_q == MKX_CFG_4B) ? MKX_LEVELS_8 : MKX_LEVELS_2)))
    else $error("A-field levels wrong");

  AST_TAIL_LEN: assert property ( // R4
    ks_ready_o |-> (tail_len == ((cfg_q == MKX_CFG_4A) ? 13'h0050 :
                                 (cfg_q == MKX_CFG_4B) ? 13'h0078 : 13'h0028)))
    else $error("tail length wrong");

  AST_DOUBLE_LEN: assert property ( // R5
    (slot_q == MKX_SLOT_DOUBLE && cfg_q == MKX_CFG_6) |=> (seg_len_o == 13'h12E8))
    else $error("double slot segment length wrong");

  AST_HALF_LEN: assert property ( // R6
    (slot_q == MKX_SLOT_HALF && cfg_q == MKX_CFG_4B) |=> (seg_len_o == 13'h0168))
    else $error("half slot segment length wrong");

  AST_LONG_LEN: assert property ( // R7
    (slot_q == MKX_SLOT_LONG672 && cfg_q == MKX_CFG_6) |=> (seg_len_o == 13'h0FE8))
    else $error("long slot segment length wrong");

  AST_TAIL_XOR: assert property ( // R9
    (consume && in_tail && ctrl_q) |=>
      (out_valid_o && out_tail_o && out_pos_o == MKX_LEN_W'($past(idx) + 13'h0008) &&
       out_bit_o == ($past(data_bit_i) ^ $past(ks_bit_i))))
    else $error("control tail bit not XORed");

  AST_DISCARD: assert property ( // R10
    (consume && in_tail && !ctrl_q) |=> !out_valid_o)
    else $error("discarded tail bit emitted");

  AST_B_OFFSET: assert property ( // R11
    (consume && !in_tail && bfmt_q == MKX_BF_UNPROT) |=>
      (out_valid_o && out_pos_o == MKX_LEN_W'($past(idx) - $past(tail_len)) &&
       out_bit_o == ($past(data_bit_i) ^ $past(ks_bit_i))))
    else $error("B-field offset wrong");

  AST_CHECK_CLEAR: assert property ( // R2
    (consume && !in_tail && bfmt_q == MKX_BF_MULTI && (pos % MKX_SUB_LEN) >= MKX_SUB_DATA)
      |=> (out_bit_o == $past(data_bit_i)))
    else $error("redundancy bit altered");

  AST_SEG_END: assert property ( // R3
    (consume && last && !field_start_i) |=> (seg_done_o && !ks_ready_o))
    else $error("segment did not end at its length");

  AST_SEG_SWAP: assert property ( // R20
    (seg_done_o && !frame_start_i) |=> (seg_second_o != $past(seg_second_o)))
    else $error("segment selection did not alternate");

  AST_IDX_RANGE: assert property ( // R8
    ks_ready_o |-> (idx < seg_len))
    else $error("segment index beyond its length");

  AST_START_READY: assert property ( // R3
    field_start_i |=> (ks_ready_o && idx == '0))
    else $error("field start did not open a segment at index zero");

  AST_4A_TAIL: assert property ( // R12
    (consume && in_tail && ctrl_q && cfg_q == MKX_CFG_4A && idx == 13'h004F) |=>
      (out_valid_o && out_tail_o && out_pos_o == 13'h0057))
    else $error("4a tail end not on A bit 87");

  AST_4B_TAIL: assert property ( // R15
    (consume && in_tail && ctrl_q && cfg_q == MKX_CFG_4B && idx == 13'h0077) |=>
      (out_valid_o && out_tail_o && out_pos_o == 13'h007F))
    else $error("4b tail end not on A bit 127");

  AST_4B_BODY: assert property ( // R17
    (consume && cfg_q == MKX_CFG_4B && idx == 13'h0078 && bfmt_q == MKX_BF_UNPROT) |=>
      (out_valid_o && !out_tail_o && out_pos_o == '0))
    else $error("4b body does not start at segment bit 120");

  AST_SINGLE_CLEAR: assert property ( // R19
    (consume && !in_tail && bfmt_q == MKX_BF_SINGLE && pos >= MKX_LEN_W'(b_len - rc_len))
      |=> (out_bit_o == $past(data_bit_i)))
    else $error("single subfield check bit altered");

  AST_FRAME_CLEAR: assert property ( // R20
    frame_start_i |=> !seg_second_o)
    else $error("frame start did not select the first segment");

  COV_CTRL_TAIL: cover property (consume && in_tail && ctrl_q && cfg_q == MKX_CFG_4B);
  COV_SINGLE:    cover property (consume && !in_tail && bfmt_q == MKX_BF_SINGLE && !do_xor);
  COV_TWO_SEG:   cover property (seg_done_o && seg_second_o);
  COV_RESTART:   cover property (field_start_i && ks_ready_o);

endmodule

// [hdl/mkx_pkg.sv]
// Shared types and constants of the multilevel key stream XOR mapper
package mkx_pkg;

  // Modulation configurations
  typedef enum logic [2:0] {
    MKX_CFG_1A = 3'h0,
    MKX_CFG_1B = 3'h1,
    MKX_CFG_2  = 3'h2,
    MKX_CFG_3  = 3'h3,
    MKX_CFG_4A = 3'h4,
    MKX_CFG_4B = 3'h5,
    MKX_CFG_5  = 3'h6,
    MKX_CFG_6  = 3'h7
  } mkx_cfg_t;

  // Slot types
  typedef enum logic [2:0] {
    MKX_SLOT_DOUBLE  = 3'h0,
    MKX_SLOT_FULL    = 3'h1,
    MKX_SLOT_HALF    = 3'h2,
    MKX_SLOT_LONG640 = 3'h3,
    MKX_SLOT_LONG672 = 3'h4
  } mkx_slot_t;

  // B-field formats
  typedef enum logic [1:0] {
    MKX_BF_UNPROT = 2'h0,
    MKX_BF_SINGLE = 2'h1,
    MKX_BF_MULTI  = 2'h2
  } mkx_bfmt_t;

  // Mapper states
  typedef enum logic [1:0] {
    MKX_ST_IDLE = 2'b00,
    MKX_ST_TAIL = 2'b01,
    MKX_ST_BODY = 2'b10
  } mkx_state_t;

  localparam int MKX_LEN_W = 13;
  typedef logic [MKX_LEN_W-1:0] mkx_len_t;

  localparam mkx_len_t MKX_TAIL_UNIT    = 13'h0028;
  localparam mkx_len_t MKX_B_DOUBLE     = 13'h0320;
  localparam mkx_len_t MKX_B_FULL       = 13'h0140;
  localparam mkx_len_t MKX_B_HALF       = 13'h0050;
  localparam mkx_len_t MKX_B_LONG640    = 13'h0280;
  localparam mkx_len_t MKX_B_LONG672    = 13'h02A0;
  localparam mkx_len_t MKX_RC_SHORT     = 13'h0010;
  localparam mkx_len_t MKX_RC_LONG      = 13'h0020;
  localparam mkx_len_t MKX_RC_SHORT_MAX = 13'h0140;
  localparam mkx_len_t MKX_SUB_LEN      = 13'h0050;
  localparam mkx_len_t MKX_SUB_DATA     = 13'h0040;
  localparam mkx_len_t MKX_A_FIRST_BIT  = 13'h0008;
  localparam logic [3:0] MKX_LEVELS_2   = 4'h2;
  localparam logic [3:0] MKX_LEVELS_4   = 4'h4;
  localparam logic [3:0] MKX_LEVELS_8   = 4'h8;

endpackage

// [hdl/mkx_seg_len.sv]
// Segment length lookup by slot type and modulation configuration
module mkx_seg_len
(
  // Field setup
  input  wire mkx_pkg::mkx_cfg_t  cfg_i,
  input  wire mkx_pkg::mkx_slot_t slot_i,
  // Lengths
  output mkx_pkg::mkx_len_t       tail_len_o,
  output mkx_pkg::mkx_len_t       b_len_o,
  output mkx_pkg::mkx_len_t       rc_len_o,
  output mkx_pkg::mkx_len_t       seg_len_o
);
  import mkx_pkg::*;

  mkx_len_t base;
  mkx_len_t mult;
  mkx_len_t tail_mult;

  always_comb
  begin
    mult      = 13'h0001;
    tail_mult = 13'h0001;
    // R4: tail portion by config
    case (cfg_i)
      MKX_CFG_2:  mult = 13'h0002;
      MKX_CFG_3:  mult = 13'h0003;
      MKX_CFG_4A:
      begin
        mult      = 13'h0002;
        tail_mult = 13'h0002;
      end
      MKX_CFG_4B:
      begin
        mult      = 13'h0003;
        tail_mult = 13'h0003;
      end
      MKX_CFG_5:  mult = 13'h0004;
      MKX_CFG_6:  mult = 13'h0006;
      default:    mult = 13'h0001;
    endcase
  end

  // R5: base B-field bits per slot type
  always_comb
  begin
    case (slot_i)
      MKX_SLOT_DOUBLE:  base = MKX_B_DOUBLE;
      MKX_SLOT_FULL:    base = MKX_B_FULL;
      MKX_SLOT_HALF:    base = MKX_B_HALF;
      MKX_SLOT_LONG640: base = MKX_B_LONG640;
      MKX_SLOT_LONG672: base = MKX_B_LONG672;
      default:          base = MKX_B_FULL;
    endcase
  end

  // R12 R15: 4a and 4b widen the tail
  assign tail_len_o = MKX_LEN_W'(MKX_TAIL_UNIT * tail_mult);
  // R6 R7 R18: B portion scales with bits per symbol
  assign b_len_o    = MKX_LEN_W'(base * mult);
  // Short fields carry the narrow redundancy check
  assign rc_len_o   = (b_len_o <= MKX_RC_SHORT_MAX) ? MKX_RC_SHORT : MKX_RC_LONG;
  // R3: segment is tail plus B portion
  assign seg_len_o  = MKX_LEN_W'(tail_len_o + b_len_o);

endmodule
